// [hdl/swr_pkg.sv]
// swr_pkg: shared constants and types of the switch routing fabric
package swr_pkg;
  localparam int unsigned SWR_NSRC = 4;
  localparam int unsigned SWR_NUSB = 4;
  localparam int unsigned SWR_NDN = 2;
  localparam int unsigned SWR_NLINK = 3;
  localparam int unsigned SWR_NWIN = 5;
  localparam int unsigned SWR_DATA_W = 64;
  localparam int unsigned SWR_FIFO_DEPTH = 32;
  localparam int unsigned SWR_NSLOT = 8;
  localparam logic [9:0] SWR_MAX_PAYLOAD = 10'h100;
  localparam logic [2:0] SWR_MPS_CODE = 3'h1;
  localparam logic [2:0] SWR_FN_OHCI0 = 3'h0;
  localparam logic [2:0] SWR_FN_OHCI1 = 3'h1;
  localparam logic [2:0] SWR_FN_EHCI = 3'h2;
  localparam int unsigned SWR_CLK_NS = 8;
  localparam int unsigned SWR_L0S_IDLE_NS = 1000;
  localparam int unsigned SWR_L1_IDLE_NS = 30000;
  localparam int unsigned SWR_SLOT_NS = 256;
  localparam int unsigned SWR_L0S_CYC = (SWR_L0S_IDLE_NS + SWR_CLK_NS - 1) / SWR_CLK_NS;
  localparam int unsigned SWR_L1_CYC = (SWR_L1_IDLE_NS + SWR_CLK_NS - 1) / SWR_CLK_NS;
  localparam int unsigned SWR_SLOT_CYC = SWR_SLOT_NS / SWR_CLK_NS;

  typedef enum logic [1:0] {SWR_K_MEM, SWR_K_IO, SWR_K_ID, SWR_K_CPL} swr_kind_e;
  typedef enum logic [2:0] {SWR_D_UP, SWR_D_DN1, SWR_D_DN2, SWR_D_F0, SWR_D_F1, SWR_D_F2} swr_dst_e;
  typedef enum logic [1:0] {SWR_ARB_RR, SWR_ARB_WRR, SWR_ARB_TBWRR} swr_arb_e;
  typedef enum logic [1:0] {SWR_LS_L0, SWR_LS_L0S, SWR_LS_L1, SWR_LS_IDLE} swr_link_e;
  typedef enum logic [1:0] {SWR_OWN_NONE, SWR_OWN_OHCI0, SWR_OWN_OHCI1, SWR_OWN_EHCI} swr_own_e;

  typedef struct packed {
    logic sop;
    logic eop;
    swr_kind_e kind;
    logic [2:0] tc;
    logic [9:0] len_b;
    logic [31:0] addr;
    logic [15:0] did;
    logic [SWR_DATA_W-1:0] data;
  } swr_word_s;

  typedef struct packed {
    logic [31:0] base;
    logic [31:0] limit;
  } swr_win_s;

  typedef struct packed {
    swr_dst_e dst;
    logic vc;
    swr_word_s w;
  } swr_out_s;
endpackage : swr_pkg

// [hdl/swr_router.sv]
// swr_router: packet fifo and the routing, arbitration and port-state logic
`timescale 1ns/1ps
`default_nettype none

module swr_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned DEPTH = 32
) (
  input wire logic clk_i, // clock
  input wire logic reset_i, // sync reset
  input wire logic [W-1:0] in_data_i, // write data
  input wire logic in_valid_i, // write request
  output logic in_ready_o, // not full
  output logic [W-1:0] out_data_o, // head word
  output logic out_valid_o, // not empty
  input wire logic out_ready_i // pop
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem_q[rd_q];
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      if (pop) rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : swr_fifo

module swr_router
  import swr_pkg::*;
#(
  parameter int unsigned USB_PORT = 2
) (
  input wire logic sys_clk_i, // 125 MHz clock
  input wire logic reset_i, // sync reset, active high
  input wire logic sf_mode_i, // 1: store-and-forward
  input wire swr_pkg::swr_arb_e arb_mode_i, // arbitration scheme
  input wire logic [3:0] wrr_weight_i [swr_pkg::SWR_NSRC], // packets per turn
  input wire logic [1:0] tb_slot_i [swr_pkg::SWR_NSLOT], // time slot owners
  input wire logic enum_done_i, // enumeration finished
  input wire logic [7:0] usb_bus_i, // bus of the host controllers
  input wire logic [4:0] usb_dev_i, // shared device number
  input wire logic [7:0] dn_sec_i [swr_pkg::SWR_NDN], // secondary bus per port
  input wire logic [7:0] dn_sub_i [swr_pkg::SWR_NDN], // subordinate bus per port
  input wire swr_pkg::swr_win_s mem_win_i [swr_pkg::SWR_NWIN], // dn1,dn2,f0,f1,f2
  input wire swr_pkg::swr_win_s io_win_i [swr_pkg::SWR_NDN], // dn1,dn2
  input wire swr_pkg::swr_word_s in_word_i [swr_pkg::SWR_NSRC], // up,dn1,dn2,usb
  input wire logic [3:0] in_valid_i, // ingress valid
  output logic [3:0] in_ready_o, // ingress ready
  output swr_pkg::swr_out_s out_o, // egress word
  output logic out_valid_o, // egress valid
  input wire logic out_ready_i, // egress ready
  output logic drop_o, // packet discarded
  output logic overlap_o, // packet claimed twice
  output logic [2:0] mps_code_o, // advertised max payload
  input wire logic [3:0] usb_hs_i, // port at high speed
  input wire logic [3:0] usb_conn_i, // device connected
  output swr_pkg::swr_own_e usb_owner_o [swr_pkg::SWR_NUSB], // serving controller
  input wire logic [1:0] dn_present_i, // downstream device present
  input wire logic [2:0] link_busy_i, // traffic on link
  input wire logic [2:0] aspm_en_i, // power management allowed
  output swr_pkg::swr_link_e link_state_o [swr_pkg::SWR_NLINK] // link state
);
  localparam int unsigned FW = $bits(swr_out_s);
  logic busy_q, drop_q, xfer, f_in_ready, f_out_valid, push, pop, miss, ovl, bad;
  logic [1:0] src_q, last_q, rr, pick, sel;
  swr_dst_e dst_q, rdst;
  logic [3:0] credit_q, req;
  logic [2:0] slot_q;
  logic [7:0] slot_cnt_q;
  logic [5:0] pkt_cnt_q;
  logic [4:0] hit;
  swr_word_s w;
  swr_out_s f_in, f_out;
  function automatic logic [1:0] rr_pick(input logic [3:0] r, input logic [1:0] last);
    logic [1:0] idx;
    logic found;
    rr_pick = last;
    found = 1'b0;
    for (int k = 1; k <= 4; k++) begin
      idx = last + k[1:0];
      if (r[idx] && !found) begin
        rr_pick = idx;
        found = 1'b1;
      end
    end
  endfunction : rr_pick
  function automatic logic in_win(input logic [31:0] a, input swr_win_s win);
    in_win = (a >= win.base) && (a <= win.limit);
  endfunction : in_win

  // only a packet start may win arbitration
  always_comb begin
    for (int s = 0; s < SWR_NSRC; s++) begin
      req[s] = in_valid_i[s] & in_word_i[s].sop;
    end
  end

  assign rr = rr_pick(req, last_q);
  always_comb begin
    case (arb_mode_i)
      SWR_ARB_RR: pick = rr;
      SWR_ARB_WRR: pick = (req[last_q] && credit_q != 4'h0) ? last_q : rr;
      // an idle slot owner lends its turn so the fabric stays work-conserving
      SWR_ARB_TBWRR: pick = req[tb_slot_i[slot_q]] ? tb_slot_i[slot_q] : rr;
      default: pick = rr;
    endcase
  end

  assign sel = busy_q ? src_q : pick;
  assign w = in_word_i[sel];

  // decode of the header word
  always_comb begin
    hit = 5'h0;
    case (w.kind)
      SWR_K_MEM: begin
        for (int t = 0; t < SWR_NWIN; t++) begin
          hit[t] = in_win(w.addr, mem_win_i[t]);
        end
      end
      SWR_K_IO: begin
        for (int t = 0; t < SWR_NDN; t++) begin
          hit[t] = in_win(w.addr, io_win_i[t]);
        end
      end
      default: begin
        for (int t = 0; t < SWR_NDN; t++) begin
          hit[t] = (w.did[15:8] >= dn_sec_i[t]) && (w.did[15:8] <= dn_sub_i[t]);
        end
        for (int f = 0; f < 3; f++) begin
          hit[2+f] = (w.did[15:8] == usb_bus_i) && (w.did[7:3] == usb_dev_i)
                     && (w.did[2:0] == 3'(f));
        end
      end
    endcase
  end

  always_comb begin
    // function hits sit inside their host port range, so they are checked apart
    ovl = (hit[2] & hit[3]) | (hit[2] & hit[4]) | (hit[3] & hit[4]) | (&hit[1:0]);
    miss = 1'b0;
    rdst = SWR_D_UP;
    if (hit[4:2] != 3'h0) begin
      rdst = hit[2] ? SWR_D_F0 : (hit[3] ? SWR_D_F1 : SWR_D_F2);
    end else if (hit[1:0] != 2'h0) begin
      rdst = hit[0] ? SWR_D_DN1 : SWR_D_DN2;
    end else begin
      miss = (sel == 2'h0);
    end
    // host controller traffic never goes to its host port, nor does that port's own traffic
    if ((sel == 2'(USB_PORT) || sel == 2'h3) && rdst == swr_dst_e'(USB_PORT)) begin
      miss = 1'b1;
    end
    if ((sel != 2'h0 && rdst == swr_dst_e'(sel)) || (sel == 2'h3 && hit[4:2] != 3'h0)) begin
      miss = 1'b1;
    end
    bad = ovl | miss | (w.len_b > SWR_MAX_PAYLOAD)
          | (!enum_done_i && (w.kind == SWR_K_MEM || w.kind == SWR_K_IO));
  end

  always_comb begin
    in_ready_o = 4'h0;
    if (busy_q || req[pick]) begin
      in_ready_o[sel] = (busy_q ? drop_q : bad) | f_in_ready;
    end
  end

  assign xfer = in_valid_i[sel] & in_ready_o[sel];
  assign push = xfer & !(busy_q ? drop_q : bad);
  assign f_in.dst = busy_q ? dst_q : rdst;
  assign f_in.vc = 1'b0;
  assign f_in.w = w;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      busy_q <= 1'b0;
      drop_q <= 1'b0;
      src_q <= 2'h0;
      dst_q <= SWR_D_UP;
    end else if (xfer && !busy_q) begin
      busy_q <= !w.eop;
      drop_q <= bad;
      src_q <= pick;
      dst_q <= rdst;
    end else if (xfer && w.eop) begin
      busy_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      drop_o <= 1'b0;
      overlap_o <= 1'b0;
    end else begin
      drop_o <= xfer & !busy_q & bad;
      overlap_o <= xfer & !busy_q & ovl;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      last_q <= 2'h0;
      credit_q <= 4'h0;
    end else if (xfer && !busy_q) begin
      last_q <= pick;
      if (pick == last_q && credit_q != 4'h0) begin
        credit_q <= credit_q - 4'h1;
      end else begin
        credit_q <= (wrr_weight_i[pick] == 4'h0) ? 4'h0 : wrr_weight_i[pick] - 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      slot_q <= 3'h0;
      slot_cnt_q <= 8'h0;
    end else if (slot_cnt_q == 8'(SWR_SLOT_CYC - 1)) begin
      slot_cnt_q <= 8'h0;
      slot_q <= slot_q + 3'h1;
    end else begin
      slot_cnt_q <= slot_cnt_q + 8'h1;
    end
  end

  swr_fifo #(
    .W(FW),
    .DEPTH(SWR_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(sys_clk_i),
    .reset_i(reset_i),
    .in_data_i(f_in),
    .in_valid_i(push),
    .in_ready_o(f_in_ready),
    .out_data_o(f_out),
    .out_valid_o(f_out_valid),
    .out_ready_i(pop)
  );

  // store-and-forward waits for a whole packet; depth covers 256 bytes at 64 bits
  assign out_valid_o = f_out_valid & (!sf_mode_i | (pkt_cnt_q != 6'h0));
  assign pop = out_valid_o & out_ready_i;
  assign out_o = f_out;
  assign mps_code_o = SWR_MPS_CODE;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pkt_cnt_q <= 6'h0;
    end else begin
      pkt_cnt_q <= pkt_cnt_q + 6'(push & w.eop) - 6'(pop & f_out.w.eop);
    end
  end

  genvar p;
  generate
    for (p = 0; p < SWR_NUSB; p++) begin : g_usb
      always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
          usb_owner_o[p] <= SWR_OWN_NONE;
        end else if (!usb_conn_i[p]) begin
          usb_owner_o[p] <= SWR_OWN_NONE;
        end else if (usb_hs_i[p]) begin
          usb_owner_o[p] <= SWR_OWN_EHCI;
        end else begin
          usb_owner_o[p] <= (p < 2) ? SWR_OWN_OHCI0 : SWR_OWN_OHCI1;
        end
      end
      a_usb_map: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        usb_conn_i[p] && !usb_hs_i[p] |=>
        usb_owner_o[p] == ((p < 2) ? SWR_OWN_OHCI0 : SWR_OWN_OHCI1))
        else $error("full speed port on wrong controller");
      a_ehci_map: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        usb_conn_i[p] && usb_hs_i[p] |=> usb_owner_o[p] == SWR_OWN_EHCI)
        else $error("high speed port not on ehci");
    end
    for (p = 0; p < SWR_NLINK; p++) begin : g_link
      logic [11:0] idle_q;
      logic empty;
      assign empty = (p > 0) ? !dn_present_i[(p > 0) ? p - 1 : 0] : 1'b0;
      always_ff @(posedge sys_clk_i) begin
        if (reset_i || link_busy_i[p]) begin
          idle_q <= 12'h0;
        end else if (idle_q != 12'hFFF) begin
          idle_q <= idle_q + 12'h1;
        end
      end
      always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
          link_state_o[p] <= SWR_LS_L0;
        end else if (empty) begin
          link_state_o[p] <= SWR_LS_IDLE;
        end else if (!aspm_en_i[p] || link_busy_i[p]) begin
          link_state_o[p] <= SWR_LS_L0;
        end else if (idle_q >= 12'(SWR_L1_CYC)) begin
          link_state_o[p] <= SWR_LS_L1;
        end else if (idle_q >= 12'(SWR_L0S_CYC)) begin
          link_state_o[p] <= SWR_LS_L0S;
        end
      end
      a_link_idle: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        empty |=> link_state_o[p] == SWR_LS_IDLE)
        else $error("empty port not idle");
      a_l0s_entry: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !empty && aspm_en_i[p] && !link_busy_i[p] && idle_q == 12'(SWR_L0S_CYC) |=>
        link_state_o[p] == SWR_LS_L0S)
        else $error("link missed l0s entry");
    end
  endgenerate
  a_sf_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    sf_mode_i && pkt_cnt_q == 6'h0 |-> !out_valid_o)
    else $error("partial packet sent in store mode");
  a_len_limit: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    push && w.sop |-> w.len_b <= SWR_MAX_PAYLOAD)
    else $error("oversized payload forwarded");
  a_vc_zero: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    out_valid_o |-> out_o.vc == 1'b0)
    else $error("packet left on nonzero channel");
  a_one_src: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $onehot0(in_ready_o))
    else $error("two ingress ports taken at once");
  a_overlap_drop: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    xfer && !busy_q && ovl |=> overlap_o && drop_o ##0 !$past(push))
    else $error("overlapping claim was forwarded");
  a_func_id: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    push && w.sop && w.kind != SWR_K_MEM && w.kind != SWR_K_IO && rdst == SWR_D_F2 && !busy_q |->
    w.did[2:0] == SWR_FN_EHCI && w.did[7:3] == usb_dev_i)
    else $error("ehci function number mismatch");
endmodule : swr_router

`default_nettype wire

// [tb/swr_rc_model.sv]
// swr_rc_model: upstream root complex model, hands out bus numbers and sinks egress words
`timescale 1ns/1ps
`default_nettype none
module swr_rc_model
  import swr_pkg::*;
(
  input wire logic sys_clk_i, // clock
  input wire logic reset_i, // sync reset
  input wire swr_pkg::swr_out_s out_i, // egress word
  input wire logic out_valid_i, // egress valid
  output logic out_ready_o, // egress ready
  output logic [7:0] bus_o, // bus of the controllers
  output logic [4:0] dev_o, // shared device number
  output logic got_o, // word taken at last edge
  output swr_pkg::swr_out_s word_o // last word taken
);
  logic [7:0] st_q;
  // controllers get a bus inside the dn2 range, ports 1 and 2 own 2..3 and 4..5
  assign bus_o = 8'h05;
  assign dev_o = 5'h03;
  // random stalls of a few cycles so the fifo really backs up
  always @(negedge sys_clk_i) begin
    st_q <= reset_i ? 8'h5A : {st_q[6:0], st_q[7] ^ st_q[5] ^ st_q[4] ^ st_q[3]};
    out_ready_o <= !reset_i && (st_q[0] | st_q[1]);
  end
  always_ff @(posedge sys_clk_i) begin
    got_o <= !reset_i && out_valid_i && out_ready_o;
    if (out_valid_i && out_ready_o) begin
      word_o <= out_i;
    end
  end
endmodule : swr_rc_model
`default_nettype wire

// [tb/tb_swr_router.sv]
// tb_swr_router: self-checking bench of the routing fabric
`timescale 1ns/1ps
`default_nettype none
module tb_swr_router
  import swr_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic sf_mode, enum_done, out_ready, out_valid, drop, ovl, got;
  swr_arb_e arb_mode;
  logic [3:0] wrr_w [SWR_NSRC];
  logic [1:0] slot [SWR_NSLOT];
  logic [7:0] usb_bus, dn_sec [SWR_NDN], dn_sub [SWR_NDN];
  logic [4:0] usb_dev;
  swr_win_s mem_win [SWR_NWIN], io_win [SWR_NDN];
  swr_word_s in_word [SWR_NSRC];
  logic [3:0] in_valid, in_ready, usb_hs, usb_conn;
  swr_out_s out, word;
  logic [2:0] mps, link_busy, aspm_en;
  swr_own_e owner [SWR_NUSB];
  logic [1:0] dn_present;
  swr_link_e link [SWR_NLINK];
  logic [15:0] rnd = 16'h0024;
  logic [63:0] wdata;
  int bad_count = 0, checks = 0, pops = 0, drops = 0, ovls = 0, exp_pops = 0, src = 0;
  swr_dst_e dsts [9] = '{SWR_D_DN1, SWR_D_DN2, SWR_D_F0, SWR_D_F1, SWR_D_F2, SWR_D_F0, SWR_D_F1, SWR_D_F2, SWR_D_DN1};

  swr_router swr_router_inst (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .sf_mode_i(sf_mode), .arb_mode_i(arb_mode),
    .wrr_weight_i(wrr_w), .tb_slot_i(slot), .enum_done_i(enum_done), .usb_bus_i(usb_bus), .usb_dev_i(usb_dev),
    .dn_sec_i(dn_sec), .dn_sub_i(dn_sub), .mem_win_i(mem_win), .io_win_i(io_win), .in_word_i(in_word),
    .in_valid_i(in_valid), .in_ready_o(in_ready), .out_o(out), .out_valid_o(out_valid), .out_ready_i(out_ready),
    .drop_o(drop), .overlap_o(ovl), .mps_code_o(mps), .usb_hs_i(usb_hs), .usb_conn_i(usb_conn), .usb_owner_o(owner),
    .dn_present_i(dn_present), .link_busy_i(link_busy), .aspm_en_i(aspm_en), .link_state_o(link));
  swr_rc_model swr_rc_model_inst (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .out_i(out), .out_valid_i(out_valid),
    .out_ready_o(out_ready), .bus_o(usb_bus), .dev_o(usb_dev), .got_o(got), .word_o(word));

  always #4 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    pops += int'(got === 1'b1);
    drops += int'(drop === 1'b1);
    ovls += int'(ovl === 1'b1);
  end

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  function automatic swr_own_e exp_own(input int p, input logic hs, input logic conn);
    if (!conn) return SWR_OWN_NONE;
    if (hs) return SWR_OWN_EHCI;
    return (p < 2) ? SWR_OWN_OHCI0 : SWR_OWN_OHCI1;
  endfunction : exp_own

  task automatic chk_val(input logic [63:0] g, input logic [63:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk_val
  task automatic chk_word(input swr_dst_e d);
    int n;
    n = 0;
    exp_pops++;
    while (pops < exp_pops && n < 60) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk_val(pops, exp_pops);
    chk_val(word.dst, d);
    chk_val(word.vc, 1'b0);
  endtask : chk_word
  task automatic send(input swr_kind_e k, input logic [31:0] a, input logic [15:0] d, input logic [9:0] len,
                      input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      rnd = lfsr(rnd);
      wdata = {4{rnd}};
      @(negedge sys_clk_i);
      in_word[src] = '{sop: i == 0, eop: i == n - 1, kind: k, tc: rnd[2:0], len_b: len, addr: a, did: d, data: wdata};
      in_valid[src] = 1'b1;
      #1;
      while (in_ready[src] !== 1'b1) begin
        @(negedge sys_clk_i);
        #1;
      end
      if (i == 0 && gap > 0) begin
        @(negedge sys_clk_i);
        in_valid[src] = 1'b0;
        repeat (gap) @(negedge sys_clk_i);
        chk_val(pops, exp_pops + (sf_mode ? 0 : 1));
      end
    end
    @(negedge sys_clk_i);
    in_valid[src] = 1'b0;
  endtask : send
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report

  initial begin
    // generous bound: the power states need about four thousand cycles
    #(SWR_CLK_NS * 20000);
    bad_count++;
    final_report();
  end

  initial begin
    {sf_mode, enum_done, in_valid, usb_hs, usb_conn, aspm_en} = '0;
    arb_mode = SWR_ARB_RR;
    link_busy = 3'h7;
    dn_present = 2'h1;
    for (int i = 0; i < SWR_NSRC; i++) begin
      wrr_w[i] = 4'(i + 1);
      in_word[i] = '0;
    end
    for (int i = 0; i < SWR_NSLOT; i++) slot[i] = 2'(i);
    for (int i = 0; i < SWR_NDN; i++) begin
      dn_sec[i] = 8'(2 + 2 * i);
      dn_sub[i] = 8'(3 + 2 * i);
      io_win[i] = '{base: 32'h0000_0100, limit: 32'h0000_01FF}; // both ports claim it on purpose
    end
    for (int i = 0; i < SWR_NWIN; i++) mem_win[i] = '{base: {4'(i + 1), 28'h0}, limit: {4'(i + 1), 28'hFFF_FFFF}};
    repeat (4) @(negedge sys_clk_i);
    reset_i = 1'b0;
    @(negedge sys_clk_i);
    @(negedge sys_clk_i);
    chk_val(out_valid, 1'b0);
    chk_val(mps, 3'h1);
    chk_val(link[2], SWR_LS_IDLE);
    chk_val(link[1], SWR_LS_L0);
    $display("test reset done");
    send(SWR_K_MEM, 32'h3000_0000, 16'h0, 10'h8, 1, 0);
    repeat (4) @(negedge sys_clk_i);
    chk_val(drops, 1);
    enum_done = 1'b1;
    for (int i = 0; i < 9; i++) begin
      arb_mode = swr_arb_e'(i % 3);
      rnd = lfsr(rnd);
      send(i < 5 ? SWR_K_MEM : (i[0] ? SWR_K_CPL : SWR_K_ID), {4'(i + 1), rnd[11:0], 16'h0},
           i == 8 ? 16'h0200 : {usb_bus, usb_dev, 3'(i - 5)}, 10'h100, 1, 0);
      chk_word(dsts[i]);
      chk_val(word.w.data, wdata);
      chk_val(word.w.tc, rnd[2:0]);
    end
    $display("test routing done");
    send(SWR_K_MEM, 32'h5000_0000, 16'h0, 10'h101, 1, 0);
    send(SWR_K_IO, 32'h0000_0150, 16'h0, 10'h4, 1, 0);
    send(SWR_K_MEM, 32'h0000_1000, 16'h0, 10'h4, 1, 0);
    repeat (4) @(negedge sys_clk_i);
    chk_val(drops, 4);
    chk_val(ovls, 1);
    chk_val(pops, exp_pops);
    $display("test refusals done");
    // host controllers reach upstream, never their own host port
    src = 3;
    send(SWR_K_MEM, 32'h0000_1000, 16'h0, 10'h4, 1, 0);
    chk_word(SWR_D_UP);
    send(SWR_K_MEM, 32'h2000_0000, 16'h0, 10'h4, 1, 0);
    repeat (4) @(negedge sys_clk_i);
    chk_val(drops, 5);
    chk_val(pops, exp_pops);
    src = 0;
    $display("test host path done");
    for (int m = 0; m < 2; m++) begin
      sf_mode = m[0];
      send(SWR_K_MEM, 32'h3000_0040, 16'h0, 10'h18, 3, 10);
      repeat (3) chk_word(SWR_D_F0);
    end
    $display("test forwarding done");
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      @(negedge sys_clk_i);
      usb_hs = (i == 0) ? 4'hF : (i == 1) ? 4'h0 : rnd[3:0];
      usb_conn = (i < 2) ? 4'hF : rnd[7:4];
      repeat (2) @(negedge sys_clk_i);
      for (int p = 0; p < SWR_NUSB; p++) chk_val(owner[p], exp_own(p, usb_hs[p], usb_conn[p]));
    end
    $display("test root hub done");
    @(negedge sys_clk_i);
    aspm_en = 3'h1;
    link_busy = 3'h0;
    repeat (SWR_L0S_CYC + 4) @(negedge sys_clk_i);
    chk_val(link[0], SWR_LS_L0S);
    chk_val(link[1], SWR_LS_L0);
    repeat (SWR_L1_CYC - SWR_L0S_CYC) @(negedge sys_clk_i);
    chk_val(link[0], SWR_LS_L1);
    link_busy = 3'h7;
    repeat (2) @(negedge sys_clk_i);
    chk_val(link[0], SWR_LS_L0);
    $display("test power states done");
    final_report();
  end
endmodule : tb_swr_router
`default_nettype wire
